// [pkg/flash_status_pkg.sv]
// Constants, encodings and timing for the serial flash status and power-down block.
// Notes on behaviour
// - Status read served in standby, even while busy
// - Opcode d7 then one status bit per clock
// - After second byte, wrap to first byte
// - Live status; ready bit in both bytes
// - Chip select high ends read, output released
// - Ready bit: 0 busy, 1 ready
// - Byte one bit 6: compare mismatch result
// - Byte one bits 5:2: fixed capacity code
// - Byte one bit 1: sector protection enabled
// - Byte one bit 0: 1 means 256-byte pages
// - Fail flag updated after each erase/program
// - Aborted operations never set fail flag
// - Byte two bits 6,4,3 read zero
// - Standby while deselected and not busy
// - Powered down: ignore all but resume
// - Opcode b9 then deselect enters power-down
// - Short or misaligned power-down command aborts
// - Reset comes up in standby
// - Power-down ignored while operation runs
// - Opcode ab then deselect resumes standby
package flash_status_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] OPCODE_STATUS_READ = 8'hd7;
  localparam logic [7:0] OPCODE_POWERDOWN   = 8'hb9;
  localparam logic [7:0] OPCODE_RESUME      = 8'hab;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Field positions inside the two status bytes
  localparam int READY_BIT     = 7;
  localparam int COMPARE_BIT   = 6;
  localparam int DENSITY_LSB   = 2;
  localparam int PROTECT_BIT   = 1;
  localparam int PAGE_SIZE_BIT = 0;
  localparam int FAIL_BIT      = 5;

  // Arbitrary value, stands in for the capacity code
  localparam logic [3:0] DENSITY_CODE = 4'h5;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic RESET_FAIL_FLAG = 1'b0;
  localparam logic RESET_CS_LEVEL  = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS         = 100;
  localparam int POWERDOWN_ENTRY_TIME_NS = 3000;
  localparam int POWERDOWN_EXIT_TIME_NS  = 3000;
  localparam int ENTRY_CYCLES_RAW = POWERDOWN_ENTRY_TIME_NS / CLK_PERIOD_NS;
  localparam int EXIT_CYCLES_RAW  = POWERDOWN_EXIT_TIME_NS / CLK_PERIOD_NS;
  localparam int ENTRY_CYCLES_INT = (ENTRY_CYCLES_RAW < 1) ? 1 : ENTRY_CYCLES_RAW;
  localparam int EXIT_CYCLES_INT  = (EXIT_CYCLES_RAW < 1) ? 1 : EXIT_CYCLES_RAW;
  localparam int TIMER_WIDTH = 8;
  localparam logic [TIMER_WIDTH-1:0] ENTRY_CYCLES = ENTRY_CYCLES_INT[TIMER_WIDTH-1:0];
  localparam logic [TIMER_WIDTH-1:0] EXIT_CYCLES  = EXIT_CYCLES_INT[TIMER_WIDTH-1:0];

  ////////////////////////////////////////////////////////////////////////////////////////////
  localparam int PIN_SYNC_STAGES   = 2;
  localparam int LEVEL_SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    state_standby      = 2'b00,
    state_entering     = 2'b01,
    state_powered_down = 2'b10,
    state_resuming     = 2'b11
  } power_state_type;

endpackage : flash_status_pkg

// [design/level_sync.sv]
// Plain flip-flop chain for carrying a level into another clock domain.
`timescale 1ns/1ps
module level_sync #(
  parameter int STAGES = 2
) (
  input  wire logic clk,
  input  wire logic d,
  output wire logic q
);

  logic [STAGES-1:0] chain;

  // First stage feeds only the second; nothing else looks at it
  always_ff @(posedge clk) begin
    chain <= {chain[STAGES-2:0], d};
  end

  assign q = chain[STAGES-1];

endmodule : level_sync

// [design/spi_flash_status_and_powerdown.sv]
// Status read and deep power-down handling for a serial flash on an SPI link.
`timescale 1ns/1ps
module spi_flash_status_and_powerdown (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  output logic      so,
  output logic      so_oe,
  input  wire logic op_busy,
  input  wire logic compare_mismatch,
  input  wire logic protect_enabled,
  input  wire logic page_size_256,
  input  wire logic op_done,
  input  wire logic op_fail,
  input  wire logic op_aborted,
  output logic      erase_program_fail_flag,
  output logic      deep_powerdown,
  output logic      standby
);
  import flash_status_pkg::*;

  localparam int entry_limit = ENTRY_CYCLES_INT;
  localparam int exit_limit  = EXIT_CYCLES_INT;

  power_state_type          power_state;
  logic [TIMER_WIDTH-1:0]   timer;
  logic                     link_reset;
  logic                     frame_clear;
  logic                     cs_second;
  logic                     cs_third;
  logic                     cs_filt;
  logic                     cs_filt_prev;
  logic                     cs_rise;
  logic                     blocked;
  logic [7:0]               status_byte_one;
  logic [7:0]               status_byte_two;
  logic [15:0]              status_link;
  logic                     blocked_link;
  logic [2:0]               in_count;
  logic [7:0]               opcode_shift;
  logic                     opcode_done;
  logic                     status_mode;
  logic [7:0]               op_byte;
  logic                     powerdown_armed;
  logic                     resume_armed;
  logic                     frame_toggle;
  logic                     powerdown_armed_s;
  logic                     resume_armed_s;
  logic                     frame_toggle_s;
  logic                     frame_seen;
  logic                     frame_valid;
  logic [3:0]               out_count;
  logic [7:0]               out_shift;
  logic [7:0]               out_byte;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // System clock side: reset for the link logic and chip select filter

  // Registered so the link side sees a clean asynchronous reset
  always_ff @(posedge clk) begin
    link_reset <= rst;
  end

  level_sync #(
    .STAGES (PIN_SYNC_STAGES)
  ) cs_sync (
    .clk (clk),
    .d   (cs_n),
    .q   (cs_second)
  );

  // Chip select counts as changed once the second and third stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_third     <= RESET_CS_LEVEL;
      cs_filt      <= RESET_CS_LEVEL;
      cs_filt_prev <= RESET_CS_LEVEL;
    end else begin
      cs_third     <= cs_second;
      if (cs_second == cs_third) begin
        cs_filt <= cs_second;
      end
      cs_filt_prev <= cs_filt;
    end
  end

  assign cs_rise = cs_filt & ~cs_filt_prev;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Status bytes, assembled every cycle so each byte sent carries fresh values

  always_ff @(posedge clk) begin
    if (rst) begin
      erase_program_fail_flag <= RESET_FAIL_FLAG;
    end else if (op_done && !op_aborted) begin
      erase_program_fail_flag <= op_fail;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_byte_one <= 8'h00;
      status_byte_two <= 8'h00;
    end else begin
      status_byte_one[READY_BIT]                  <= ~op_busy;
      status_byte_one[COMPARE_BIT]                <= compare_mismatch;
      status_byte_one[DENSITY_LSB+3:DENSITY_LSB]  <= DENSITY_CODE;
      status_byte_one[PROTECT_BIT]                <= protect_enabled;
      status_byte_one[PAGE_SIZE_BIT]              <= page_size_256;
      // Unused bits held at zero, including the don't-care ones
      status_byte_two                             <= 8'h00;
      status_byte_two[READY_BIT]                  <= ~op_busy;
      status_byte_two[FAIL_BIT]                   <= erase_program_fail_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Power state: entry and exit are decided only after the frame has ended

  assign frame_valid = (frame_toggle_s != frame_seen);

  always_ff @(posedge clk) begin
    if (rst) begin
      frame_seen <= 1'b0;
    end else if (cs_rise) begin
      frame_seen <= frame_toggle_s;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      power_state <= state_standby;
      timer       <= '0;
    end else begin
      case (power_state)
        state_standby: begin
          // A busy array makes the request vanish; the host has to resend it
          if (cs_rise && frame_valid && powerdown_armed_s && !op_busy) begin
            power_state <= state_entering;
            timer       <= ENTRY_CYCLES - 8'h01;
          end
        end
        state_entering: begin
          if (timer == '0) begin
            power_state <= state_powered_down;
          end else begin
            timer <= timer - 8'h01;
          end
        end
        state_powered_down: begin
          if (cs_rise && frame_valid && resume_armed_s) begin
            power_state <= state_resuming;
            timer       <= EXIT_CYCLES - 8'h01;
          end
        end
        state_resuming: begin
          if (timer == '0) begin
            power_state <= state_standby;
          end else begin
            timer <= timer - 8'h01;
          end
        end
        default: begin
          power_state <= state_standby;
          timer       <= '0;
        end
      endcase
    end
  end

  assign blocked = (power_state != state_standby);

  always_ff @(posedge clk) begin
    if (rst) begin
      deep_powerdown <= 1'b0;
      standby        <= 1'b0;
    end else begin
      deep_powerdown <= (power_state == state_powered_down);
      standby        <= cs_filt && !op_busy && (power_state == state_standby);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Crossings: levels into the link domain, frame results back out

  genvar bit_index;
  generate
    for (bit_index = 0; bit_index < 16; bit_index++) begin : status_cross
      level_sync #(
        .STAGES (LEVEL_SYNC_STAGES)
      ) status_bit_sync (
        .clk (sck),
        .d   ((bit_index < 8) ? status_byte_one[bit_index % 8] : status_byte_two[bit_index % 8]),
        .q   (status_link[bit_index])
      );
    end
  endgenerate

  level_sync #(
    .STAGES (LEVEL_SYNC_STAGES)
  ) blocked_sync (
    .clk (sck),
    .d   (blocked),
    .q   (blocked_link)
  );

  // These flags stand still once the frame has ended, so a plain level crossing is safe
  level_sync #(
    .STAGES (LEVEL_SYNC_STAGES)
  ) powerdown_sync (
    .clk (clk),
    .d   (powerdown_armed),
    .q   (powerdown_armed_s)
  );

  level_sync #(
    .STAGES (LEVEL_SYNC_STAGES)
  ) resume_sync (
    .clk (clk),
    .d   (resume_armed),
    .q   (resume_armed_s)
  );

  level_sync #(
    .STAGES (LEVEL_SYNC_STAGES)
  ) toggle_sync (
    .clk (clk),
    .d   (frame_toggle),
    .q   (frame_toggle_s)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Link side, rising edge: opcode capture

  assign frame_clear = cs_n | link_reset;
  assign op_byte     = opcode_done ? opcode_shift : {opcode_shift[6:0], si};

  always_ff @(posedge sck or posedge frame_clear) begin
    if (frame_clear) begin
      in_count     <= 3'h0;
      opcode_shift <= 8'h00;
      opcode_done  <= 1'b0;
      status_mode  <= 1'b0;
    end else begin
      in_count <= in_count + 3'h1;
      if (!opcode_done) begin
        opcode_shift <= {opcode_shift[6:0], si};
        if (in_count == 3'h7) begin
          opcode_done <= 1'b1;
          // Served whatever the array is doing; only a power state other than standby shuts it out
          status_mode <= ({opcode_shift[6:0], si} == OPCODE_STATUS_READ)
                         && !blocked_link;
        end
      end
    end
  end

  // Recomputed on every edge so only a byte-aligned end of frame leaves a flag set
  always_ff @(posedge sck or posedge link_reset) begin
    if (link_reset) begin
      powerdown_armed <= 1'b0;
      resume_armed    <= 1'b0;
      frame_toggle    <= 1'b0;
    end else begin
      powerdown_armed <= (in_count == 3'h7) && (op_byte == OPCODE_POWERDOWN);
      resume_armed    <= (in_count == 3'h7) && (op_byte == OPCODE_RESUME);
      if ((in_count == 3'h0) && !opcode_done) begin
        frame_toggle <= ~frame_toggle;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Link side, falling edge: status shift-out

  assign out_byte = out_count[3] ? status_link[15:8] : status_link[7:0];

  always_ff @(negedge sck or posedge frame_clear) begin
    if (frame_clear) begin
      out_count <= 4'h0;
      out_shift <= 8'h00;
      so        <= 1'b0;
      so_oe     <= 1'b0;
    end else if (status_mode) begin
      so_oe     <= 1'b1;
      out_count <= out_count + 4'h1;
      if (out_count[2:0] == 3'h0) begin
        // Each byte loads from the live copy, so ready is refreshed per byte
        so        <= out_byte[7];
        out_shift <= {out_byte[6:0], 1'b0};
      end else begin
        so        <= out_shift[7];
        out_shift <= {out_shift[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_fail_set;
    @(posedge clk) disable iff (rst)
    (op_done && !op_aborted && op_fail) |=> erase_program_fail_flag ##1 status_byte_two[FAIL_BIT];
  endproperty
  a_fail_set: assert property (p_fail_set) else $error("fail flag not set");

  property p_fail_clear;
    @(posedge clk) disable iff (rst)
    (op_done && !op_aborted && !op_fail) |=> !erase_program_fail_flag;
  endproperty
  a_fail_clear: assert property (p_fail_clear) else $error("fail flag not cleared");

  property p_abort_keeps;
    @(posedge clk) disable iff (rst)
    (op_done && op_aborted) |=> $stable(erase_program_fail_flag);
  endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("abort changed fail flag");

  property p_ready_both;
    @(posedge clk) disable iff (rst)
    !$past(rst) |-> (status_byte_one[READY_BIT] == status_byte_two[READY_BIT])
                    && (status_byte_one[READY_BIT] == !$past(op_busy));
  endproperty
  a_ready_both: assert property (p_ready_both) else $error("ready bit wrong");

  property p_fixed_fields;
    @(posedge clk) disable iff (rst)
    !$past(rst) |-> (status_byte_one[DENSITY_LSB+3:DENSITY_LSB] == DENSITY_CODE)
                    && (status_byte_two[6] == 1'b0) && (status_byte_two[4:3] == 2'b00);
  endproperty
  a_fixed_fields: assert property (p_fixed_fields) else $error("fixed status bits wrong");

  property p_entry_time;
    @(posedge clk) disable iff (rst)
    (power_state == state_entering && $past(power_state) == state_standby)
      |-> ##[1:entry_limit] (power_state == state_powered_down);
  endproperty
  a_entry_time: assert property (p_entry_time) else $error("power-down entry too slow");

  property p_exit_time;
    @(posedge clk) disable iff (rst)
    (power_state == state_resuming && $past(power_state) == state_powered_down)
      |-> ##[1:exit_limit] (power_state == state_standby);
  endproperty
  a_exit_time: assert property (p_exit_time) else $error("resume too slow");

  property p_busy_ignores;
    @(posedge clk) disable iff (rst)
    (cs_rise && op_busy && power_state == state_standby) |=> (power_state == state_standby);
  endproperty
  a_busy_ignores: assert property (p_busy_ignores) else $error("power-down taken while busy");

  property p_powered_down_holds;
    @(posedge clk) disable iff (rst)
    (power_state == state_powered_down && !(cs_rise && frame_valid && resume_armed_s))
      |=> (power_state == state_powered_down);
  endproperty
  a_powered_down_holds: assert property (p_powered_down_holds) else $error("left power-down");

  property p_after_reset;
    @(posedge clk) disable iff (rst)
    $fell(rst) |-> (power_state == state_standby) ##1 !deep_powerdown;
  endproperty
  a_after_reset: assert property (p_after_reset) else $error("not standby after reset");

  property p_released_when_high;
    @(posedge clk) disable iff (rst)
    cs_filt |-> !so_oe;
  endproperty
  a_released_when_high: assert property (p_released_when_high) else $error("so driven");

  property p_standby_out;
    @(posedge clk) disable iff (rst)
    (cs_filt && !op_busy && power_state == state_standby) |=> standby;
  endproperty
  a_standby_out: assert property (p_standby_out) else $error("standby not shown");

endmodule : spi_flash_status_and_powerdown

// [testbench/spi_host_model.sv]
// Behavioural SPI host that shifts commands in and status bits out, mode 0.
`timescale 1ns/1ps
module spi_host_model (
  output logic        sck,
  output logic        cs_n,
  output logic        si,
  input  wire logic   so,
  input  wire logic   so_oe,
  output logic [15:0] rx_word,
  output logic        oe_seen,
  output logic        oe_after,
  output int          rx_count
);

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sck      = 1'b0;
    cs_n     = 1'b1;
    si       = 1'b0;
    rx_word  = 16'h0000;
    oe_seen  = 1'b0;
    oe_after = 1'b0;
    rx_count = 0;
  end

  // Data line carries no meaning between frames, so keep it moving
  always #50 if (cs_n) si = ~si;

  ////////////////////////////////////////////////////////////////////////////////
  // Sck only runs inside a frame; trailing bits after the opcode are random filler
  task automatic xfer(input logic [7:0] op, input int tx_bits, input int rd_bits);
    rx_word = 16'h0000;
    oe_seen = 1'b0;
    #37 cs_n = 1'b0;
    #80;
    for (int i = 0; i < tx_bits + rd_bits; i++) begin
      si = (i < 8 && i < tx_bits) ? op[3'(7 - i)] : 1'($urandom);
      #62.5 sck = 1'b1;
      if (i >= tx_bits) begin
        // A released line floats; read it as the inverse of the idle low level
        rx_word = {rx_word[14:0], so_oe ? so : 1'b1};
        oe_seen = oe_seen | so_oe;
      end
      #62.5 sck = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    #5 oe_after = so_oe;
    rx_count = rx_count + 1;
  endtask : xfer

endmodule : spi_host_model

// [testbench/tb.sv]
// Self-checking bench for the status read and deep power-down block.
`timescale 1ns/1ps
module tb;
  import flash_status_pkg::*;

  logic        clk;
  logic        rst;
  logic        sck;
  logic        cs_n;
  logic        si;
  logic        so;
  logic        so_oe;
  logic        op_busy;
  logic        compare_mismatch;
  logic        protect_enabled;
  logic        page_size_256;
  logic        op_done;
  logic        op_fail;
  logic        op_aborted;
  logic        erase_program_fail_flag;
  logic        deep_powerdown;
  logic        standby;
  logic [15:0] rx_word;
  logic        oe_seen;
  logic        oe_after;
  int          rx_count;
  logic [17:0] exp_q[$];
  logic [15:0] w;
  logic [17:0] probe_word;
  logic        fail_model = 1'b0;
  int          n_errors = 0;
  int          check_count = 0;
  event        probe_ev;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  spi_flash_status_and_powerdown dut (
    .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .op_busy(op_busy), .compare_mismatch(compare_mismatch),
    .protect_enabled(protect_enabled), .page_size_256(page_size_256), .op_done(op_done),
    .op_fail(op_fail), .op_aborted(op_aborted),
    .erase_program_fail_flag(erase_program_fail_flag), .deep_powerdown(deep_powerdown),
    .standby(standby)
  );

  spi_host_model host (
    .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .rx_word(rx_word),
    .oe_seen(oe_seen), .oe_after(oe_after), .rx_count(rx_count)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [17:0] seen, input logic [17:0] want);
    check_count++;
    if (seen !== want) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic finish_test;
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  // Results are compared in the order their expectations were queued
  always @(rx_count) check({oe_seen, oe_after, rx_word}, exp_q.pop_front());
  assign probe_word = {15'h0000, deep_powerdown, standby, erase_program_fail_flag};
  always @(probe_ev) check(probe_word, exp_q.pop_front());

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick

  function automatic logic [15:0] status_word();
    return {~op_busy, compare_mismatch, DENSITY_CODE, protect_enabled, page_size_256,
            ~op_busy, 1'b0, fail_model, 5'b00000};
  endfunction : status_word

  task automatic probe(input logic dp, input logic sb);
    exp_q.push_back({15'h0000, dp, sb, fail_model});
    -> probe_ev;
  endtask : probe

  // Leaves chip select high long enough between frames for the decision to settle
  task automatic frame(input logic [7:0] op, input int tx, input int rd, input logic [17:0] want);
    exp_q.push_back(want);
    host.xfer(op, tx, rd);
    tick(8);
  endtask : frame

  task automatic finish_op(input logic fail, input logic abort);
    op_fail    = fail;
    op_aborted = abort;
    op_done    = 1'b1;
    tick(1);
    op_done    = 1'b0;
    if (!abort) fail_model = fail;
    tick(3);
    probe(1'b0, 1'b1);
  endtask : finish_op

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    op_busy = 1'b0;
    compare_mismatch = 1'b0;
    protect_enabled = 1'b0;
    page_size_256 = 1'b1;
    op_done = 1'b0;
    op_fail = 1'b0;
    op_aborted = 1'b0;
    void'($urandom(70));
    tick(5);
    rst = 1'b0;
    tick(6);
    probe(1'b0, 1'b1);
    finish_op(1'b1, 1'b0);
    finish_op(1'b0, 1'b1);
    finish_op(1'b0, 1'b0);
    finish_op(1'b1, 1'b1);
    finish_op(1'b1, 1'b0);
    // 32 bits read: the last 16 come from the wrapped second pass
    for (int k = 0; k < 6; k++) begin
      {op_busy, compare_mismatch, protect_enabled, page_size_256} = 4'($urandom);
      if (k == 0) op_busy = 1'b1;
      tick(2);
      frame(OPCODE_STATUS_READ, 8, 32, {2'b10, status_word()});
    end
    op_busy = 1'b0;
    tick(2);
    w = status_word();
    frame(OPCODE_STATUS_READ, 8, 5, {2'b10, 11'h000, w[15:11]});
    // Ready has to rise inside one long poll once the operation ends
    op_busy = 1'b1;
    fork
      frame(OPCODE_STATUS_READ, 8, 64, {2'b10, w});
      begin
        tick(20);
        op_busy = 1'b0;
      end
    join
    frame(OPCODE_POWERDOWN, 7, 0, 18'h00000);
    tick(40);
    probe(1'b0, 1'b1);
    frame(OPCODE_POWERDOWN, 12, 0, 18'h00000);
    tick(40);
    probe(1'b0, 1'b1);
    op_busy = 1'b1;
    frame(OPCODE_POWERDOWN, 8, 0, 18'h00000);
    tick(40);
    probe(1'b0, 1'b0);
    op_busy = 1'b0;
    tick(2);
    frame(OPCODE_POWERDOWN, 16, 0, 18'h00000);
    tick(40);
    probe(1'b1, 1'b0);
    frame(OPCODE_STATUS_READ, 8, 16, {2'b00, 16'hffff});
    frame(OPCODE_RESUME, 5, 0, 18'h00000);
    tick(40);
    probe(1'b1, 1'b0);
    frame(OPCODE_RESUME, 8, 0, 18'h00000);
    tick(40);
    probe(1'b0, 1'b1);
    frame(OPCODE_STATUS_READ, 8, 16, {2'b10, status_word()});
    frame(OPCODE_POWERDOWN, 8, 0, 18'h00000);
    tick(40);
    rst = 1'b1;
    tick(5);
    rst = 1'b0;
    fail_model = RESET_FAIL_FLAG;
    tick(6);
    probe(1'b0, 1'b1);
    tick(2);
    finish_test();
  end

  // Whole sequence needs well under 200 us
  initial begin
    #1000000;
    n_errors++;
    finish_test();
  end

endmodule : tb
